// *** hdl/rfxcb_pkg.sv ***
package rfxcb_pkg;

  // Register offsets on the control bus
  localparam logic [6:0] RFXCB_OFS_NUM1_LOW  = 7'h1e;
  localparam logic [6:0] RFXCB_OFS_NUM2_HIGH = 7'h1f;
  localparam logic [6:0] RFXCB_OFS_NUM2_LOW  = 7'h20;
  localparam logic [6:0] RFXCB_OFS_NUM3_HIGH = 7'h21;
  localparam logic [6:0] RFXCB_OFS_NUM3_LOW  = 7'h22;
  localparam logic [6:0] RFXCB_OFS_NUM4_HIGH = 7'h23;
  localparam logic [6:0] RFXCB_OFS_NUM4_LOW  = 7'h24;
  localparam logic [6:0] RFXCB_OFS_NUM5_HIGH = 7'h25;
  localparam logic [6:0] RFXCB_OFS_NUM5_LOW  = 7'h26;
  localparam logic [6:0] RFXCB_OFS_DEN1_HIGH = 7'h27;

  // Register and field geometry
  localparam int RFXCB_ADDR_W   = 7;
  localparam int RFXCB_BYTE_W   = 8;
  localparam int RFXCB_COEFF_W  = 16;
  localparam int RFXCB_NUM_REGS = 10;
  localparam int RFXCB_HIGH_LSB = 8;

  // Reset values; bytes with no documented value reset to zero
  localparam logic [7:0] RFXCB_RST_NUM1_LOW  = 8'h00;
  localparam logic [7:0] RFXCB_RST_NUM2_HIGH = 8'h67;
  localparam logic [7:0] RFXCB_RST_NUM2_LOW  = 8'h5d;
  localparam logic [7:0] RFXCB_RST_NUM3_HIGH = 8'h6b;
  localparam logic [7:0] RFXCB_RST_NUM3_LOW  = 8'h00;
  localparam logic [7:0] RFXCB_RST_NUM4_HIGH = 8'h96;
  localparam logic [7:0] RFXCB_RST_NUM4_LOW  = 8'h66;
  localparam logic [7:0] RFXCB_RST_NUM5_HIGH = 8'h67;
  localparam logic [7:0] RFXCB_RST_NUM5_LOW  = 8'h5d;
  localparam logic [7:0] RFXCB_RST_DEN1_HIGH = 8'h7d;

  // Answer on unmapped reads
  localparam logic [7:0] RFXCB_RD_UNMAPPED = 8'h00;

endpackage

// *** hdl/rfxcb_byte_reg.sv ***
`timescale 1ns/1ps
`default_nettype none

// One read/write coefficient byte with its own reset value
module rfxcb_byte_reg
  import rfxcb_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Stored value
  output logic      [7:0] value
);

  logic [7:0] byte_ff;   // Stored byte
  logic [7:0] nxt_byte;  // Next stored byte

  // Next value: a write replaces all eight bits
  always_comb begin
    nxt_byte = byte_ff;
    if (wr_en) begin
      nxt_byte = wr_data;
    end
  end

  // Register with reset constant
  always_ff @(posedge clk) begin
    if (rst) begin
      byte_ff <= RST_VAL;
    end else begin
      byte_ff <= nxt_byte;
    end
  end

  assign value = byte_ff;

endmodule

`default_nettype wire

// *** hdl/rfxcb_coeff_join.sv ***
`timescale 1ns/1ps
`default_nettype none

// Joins an upper and a lower byte into one signed coefficient
module rfxcb_coeff_join
  import rfxcb_pkg::*;
(
  // Byte halves
  input  wire logic        [7:0]  high_byte,
  input  wire logic        [7:0]  low_byte,
  // Joined coefficient, two's complement
  output logic signed      [15:0] coeff
);

  // Upper byte carries the sign bit
  assign coeff = signed'({high_byte, low_byte});

endmodule

`default_nettype wire

// *** hdl/rfxcb_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

// Right channel effects filter coefficient bank
// Software reaches single bytes at their offsets; the filter
// datapath sees the joined coefficients one cycle after the byte
// registers change. Reads answer one cycle after the strobe, and
// unmapped offsets answer zero with no hit.
module rfxcb_bank
  import rfxcb_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Register access port from the control bus
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic        [6:0]   reg_addr,
  input  wire logic        [7:0]   reg_wdata,
  output logic             [7:0]   reg_rdata,
  output logic                     reg_rvalid,
  output logic                     reg_hit,
  // Joined coefficients to the filter datapath
  output logic signed      [15:0]  numerator_coeff_one_low,
  output logic signed      [15:0]  numerator_coeff_two,
  output logic signed      [15:0]  numerator_coeff_three,
  output logic signed      [15:0]  numerator_coeff_four,
  output logic signed      [15:0]  numerator_coeff_five,
  output logic signed      [15:0]  denominator_coeff_one_high
);

  // Byte index within the bank
  localparam int IDX_N1L = 0;
  localparam int IDX_N2H = 1;
  localparam int IDX_N2L = 2;
  localparam int IDX_N3H = 3;
  localparam int IDX_N3L = 4;
  localparam int IDX_N4H = 5;
  localparam int IDX_N4L = 6;
  localparam int IDX_N5H = 7;
  localparam int IDX_N5L = 8;
  localparam int IDX_D1H = 9;

  // Offsets in index order
  localparam logic [6:0] OFS_TAB [RFXCB_NUM_REGS] = '{
    RFXCB_OFS_NUM1_LOW,  RFXCB_OFS_NUM2_HIGH, RFXCB_OFS_NUM2_LOW,
    RFXCB_OFS_NUM3_HIGH, RFXCB_OFS_NUM3_LOW,  RFXCB_OFS_NUM4_HIGH,
    RFXCB_OFS_NUM4_LOW,  RFXCB_OFS_NUM5_HIGH, RFXCB_OFS_NUM5_LOW,
    RFXCB_OFS_DEN1_HIGH
  };

  // Reset values in index order
  localparam logic [7:0] RST_TAB [RFXCB_NUM_REGS] = '{
    RFXCB_RST_NUM1_LOW,  RFXCB_RST_NUM2_HIGH, RFXCB_RST_NUM2_LOW,
    RFXCB_RST_NUM3_HIGH, RFXCB_RST_NUM3_LOW,  RFXCB_RST_NUM4_HIGH,
    RFXCB_RST_NUM4_LOW,  RFXCB_RST_NUM5_HIGH, RFXCB_RST_NUM5_LOW,
    RFXCB_RST_DEN1_HIGH
  };

  // Address decode, used for both write select and read hit
  function automatic logic [RFXCB_NUM_REGS-1:0] dec_addr(
    input logic [6:0] addr
  );
    logic [RFXCB_NUM_REGS-1:0] sel;
    sel = '0;
    for (int i = 0; i < RFXCB_NUM_REGS; i++) begin
      sel[i] = (addr == OFS_TAB[i]);
    end
    return sel;
  endfunction

  logic [RFXCB_NUM_REGS-1:0] wr_sel;             // Write strobes
  logic [RFXCB_NUM_REGS-1:0] rd_sel;             // Read select
  logic [7:0]                byte_val [RFXCB_NUM_REGS]; // Stored bytes

  // Decode of the access port
  always_comb begin
    wr_sel = reg_wr ? dec_addr(reg_addr) : '0;
    rd_sel = dec_addr(reg_addr);
  end

  // Storage bytes, each with its own reset constant
  for (genvar g = 0; g < RFXCB_NUM_REGS; g++) begin : g_byte
    rfxcb_byte_reg #(
      .RST_VAL (RST_TAB[g])
    ) u_byte (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (wr_sel[g]),
      .wr_data (reg_wdata),
      .value   (byte_val[g])
    );
  end

  // Read path state
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       rvalid_ff;
  logic       nxt_rvalid;
  logic       hit_ff;
  logic       nxt_hit;

  // Read mux: stored byte or zero for unmapped
  always_comb begin
    nxt_rdata  = rdata_ff;
    nxt_rvalid = reg_rd;
    nxt_hit    = 1'b0;
    // Same-cycle write lands after the read takes the old byte
    if (reg_rd) begin
      // Unmapped offsets answer zero
      nxt_rdata = RFXCB_RD_UNMAPPED;
      for (int i = 0; i < RFXCB_NUM_REGS; i++) begin
        if (rd_sel[i]) begin
          nxt_rdata = byte_val[i];
        end
      end
      nxt_hit = |rd_sel;
    end else if (reg_wr) begin
      nxt_hit = |rd_sel;
    end
  end

  // Read path registers
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
      hit_ff    <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      hit_ff    <= nxt_hit;
    end
  end

  assign reg_rdata  = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign reg_hit    = hit_ff;

  // Joined coefficient values before registering
  logic signed [15:0] join_num2;  // Numerator two pair
  logic signed [15:0] join_num3;  // Numerator three pair
  logic signed [15:0] join_num4;  // Numerator four pair
  logic signed [15:0] join_num5;  // Numerator five pair

  // pair bytes signed
  // Numerator two pair
  rfxcb_coeff_join u_join_num2 (
    .high_byte (byte_val[IDX_N2H]),
    .low_byte  (byte_val[IDX_N2L]),
    .coeff     (join_num2)
  );

  // Numerator three pair
  rfxcb_coeff_join u_join_num3 (
    .high_byte (byte_val[IDX_N3H]),
    .low_byte  (byte_val[IDX_N3L]),
    .coeff     (join_num3)
  );

  // Numerator four pair
  rfxcb_coeff_join u_join_num4 (
    .high_byte (byte_val[IDX_N4H]),
    .low_byte  (byte_val[IDX_N4L]),
    .coeff     (join_num4)
  );

  // Numerator five pair
  rfxcb_coeff_join u_join_num5 (
    .high_byte (byte_val[IDX_N5H]),
    .low_byte  (byte_val[IDX_N5L]),
    .coeff     (join_num5)
  );

  // Partial pairs: the missing half lives outside this bank, so
  // the known half sits in its own lane and the rest reads zero.
  // Pairs are not swapped atomically; the filter must be idle
  // while software rewrites both bytes of one coefficient.
  // idle-time update assumed

  // Numerator one lane: low byte only, upper half zero
  logic signed [15:0] num1_ff;   // Registered lane
  logic signed [15:0] nxt_num1;  // Next lane value

  // Next value from the stored low byte
  always_comb begin
    nxt_num1 = signed'({8'h00, byte_val[IDX_N1L]});
  end

  // Lane register, cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      num1_ff <= 16'sh0000;
    end else begin
      num1_ff <= nxt_num1;
    end
  end

  // Numerator two lane
  logic signed [15:0] num2_ff;   // Registered lane
  logic signed [15:0] nxt_num2;  // Next lane value

  // Next value follows the joined pair
  always_comb begin
    nxt_num2 = join_num2;
  end

  // Lane register, cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      num2_ff <= 16'sh0000;
    end else begin
      num2_ff <= nxt_num2;
    end
  end

  // Numerator three lane
  logic signed [15:0] num3_ff;   // Registered lane
  logic signed [15:0] nxt_num3;  // Next lane value

  // Next value follows the joined pair
  always_comb begin
    nxt_num3 = join_num3;
  end

  // Lane register, cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      num3_ff <= 16'sh0000;
    end else begin
      num3_ff <= nxt_num3;
    end
  end

  // Numerator four lane
  logic signed [15:0] num4_ff;   // Registered lane
  logic signed [15:0] nxt_num4;  // Next lane value

  // Next value follows the joined pair
  always_comb begin
    nxt_num4 = join_num4;
  end

  // Lane register, cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      num4_ff <= 16'sh0000;
    end else begin
      num4_ff <= nxt_num4;
    end
  end

  // Numerator five lane
  logic signed [15:0] num5_ff;   // Registered lane
  logic signed [15:0] nxt_num5;  // Next lane value

  // Next value follows the joined pair
  always_comb begin
    nxt_num5 = join_num5;
  end

  // Lane register, cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      num5_ff <= 16'sh0000;
    end else begin
      num5_ff <= nxt_num5;
    end
  end

  // Denominator one lane: upper byte only, lower half zero
  logic signed [15:0] den1_ff;   // Registered lane
  logic signed [15:0] nxt_den1;  // Next lane value

  // Next value from the stored upper byte
  always_comb begin
    nxt_den1 = signed'({byte_val[IDX_D1H], 8'h00});
  end

  // Lane register, cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      den1_ff <= 16'sh0000;
    end else begin
      den1_ff <= nxt_den1;
    end
  end

  // Outputs straight from the lane registers
  assign numerator_coeff_one_low    = num1_ff;
  assign numerator_coeff_two        = num2_ff;
  assign numerator_coeff_three      = num3_ff;
  assign numerator_coeff_four       = num4_ff;
  assign numerator_coeff_five       = num5_ff;
  assign denominator_coeff_one_high = den1_ff;

endmodule

`default_nettype wire

// *** tb/rfxcb_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

// Port-level checks beside the coefficient bank
module rfxcb_chk
  import rfxcb_pkg::*;
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // Register port
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic        [6:0]  reg_addr,
  input wire logic        [7:0]  reg_wdata,
  input wire logic        [7:0]  reg_rdata,
  input wire logic               reg_rvalid,
  input wire logic               reg_hit,
  // Coefficients
  input wire logic signed [15:0] numerator_coeff_one_low,
  input wire logic signed [15:0] numerator_coeff_two,
  input wire logic signed [15:0] numerator_coeff_three,
  input wire logic signed [15:0] numerator_coeff_four,
  input wire logic signed [15:0] numerator_coeff_five,
  input wire logic signed [15:0] denominator_coeff_one_high
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Offset falls inside the bank
  wire logic mp = reg_addr >= RFXCB_OFS_NUM1_LOW &&
    reg_addr <= RFXCB_OFS_DEN1_HIGH;
  wire logic ac = reg_rd || reg_wr;

  a_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_rd_only: assert property (!reg_rd |=> !reg_rvalid)
    else $error("spurious read valid");
  a_hit_map: assert property (ac && mp |=> reg_hit)
    else $error("mapped access not hit");
  a_hit_unmap: assert property (!(ac && mp) |=> !reg_hit)
    else $error("spurious hit");
  a_unmap_zero: assert property (
    reg_rd && !mp |=> reg_rdata == RFXCB_RD_UNMAPPED)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_wr_coef_two: assert property (
    reg_wr && reg_addr == RFXCB_OFS_NUM2_HIGH
    |-> ##2 numerator_coeff_two[15:8] == $past(reg_wdata, 2))
    else $error("upper byte not in coefficient");
  // Outputs read zero one edge after reset, then the reset pairs
  a_rst_vals: assert property (
    !rst && $past(rst) && $past(rst, 2)
    |=> {numerator_coeff_one_low, numerator_coeff_two,
    numerator_coeff_three, numerator_coeff_four,
    numerator_coeff_five, denominator_coeff_one_high}
    == {8'h00, RFXCB_RST_NUM1_LOW,
    RFXCB_RST_NUM2_HIGH, RFXCB_RST_NUM2_LOW,
    RFXCB_RST_NUM3_HIGH, RFXCB_RST_NUM3_LOW,
    RFXCB_RST_NUM4_HIGH, RFXCB_RST_NUM4_LOW,
    RFXCB_RST_NUM5_HIGH, RFXCB_RST_NUM5_LOW,
    RFXCB_RST_DEN1_HIGH, 8'h00})
    else $error("bad reset values");
  a_zero_fill: assert property (
    numerator_coeff_one_low[15:8] == 8'h00
    && denominator_coeff_one_high[7:0] == 8'h00)
    else $error("bad fill");
  // Main scenarios
  c_rd_map: cover property (reg_rd && mp);
  c_wr_map: cover property (reg_wr && mp);
  c_rd_unmap: cover property (reg_rd && !mp);
endmodule

bind rfxcb_bank rfxcb_chk rfxcb_chk_inst (.clk(clk), .rst(rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .reg_hit(reg_hit), .numerator_coeff_one_low(numerator_coeff_one_low),
  .numerator_coeff_two(numerator_coeff_two),
  .numerator_coeff_three(numerator_coeff_three),
  .numerator_coeff_four(numerator_coeff_four),
  .numerator_coeff_five(numerator_coeff_five),
  .denominator_coeff_one_high(denominator_coeff_one_high));
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import rfxcb_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [6:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, erd;
  logic reg_rvalid, reg_hit, ev, eh;
  logic signed [15:0] k0, k1, k2, k3, k4, k5;
  // Shadow bytes, delayed copy, reset image
  logic [7:0] sh [10], sd [10], rsv [10];
  int miscompares = 0, check_count = 0, cyc = 0, i;
  logic [31:0] seed = 32'h77115387;

  rfxcb_bank rfxcb_bank_inst (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
    .numerator_coeff_one_low(k0), .numerator_coeff_two(k1),
    .numerator_coeff_three(k2), .numerator_coeff_four(k3),
    .numerator_coeff_five(k4), .denominator_coeff_one_high(k5));

  always #2 clk = ~clk;

  function automatic logic mp(logic [6:0] a);
    return a >= RFXCB_OFS_NUM1_LOW && a <= RFXCB_OFS_DEN1_HIGH;
  endfunction
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One access; returns at the edge that takes it
  task automatic op(input logic w, r, input logic [6:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask
  // Two-edge reset, then the documented pairs
  task automatic do_rst();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Outputs read zero for one edge, then the reset pairs
    @(posedge clk);
    @(negedge clk);
    chk(k1 === 16'sh675d, "coef two reset");
    chk(k2 === 16'sh6b00, "coef three reset");
    chk(k3 === 16'sh9666, "coef four reset");
    chk(k4 === 16'sh675d, "coef five reset");
    chk(k5 === 16'sh7d00, "denominator reset");
    @(posedge clk);
  endtask
  // Write a pair back to back, then read it as signed
  task automatic pair(input logic [7:0] h, l, input logic signed [15:0] v);
    op(1'b1, 1'b0, RFXCB_OFS_NUM4_HIGH, h);
    op(1'b1, 1'b0, RFXCB_OFS_NUM4_LOW, l);
    op(1'b0, 1'b0, 7'h00, 8'h00);
    @(negedge clk);
    chk(k3 === v, "signed join");
    @(posedge clk);
  endtask

  // Reference model on the bank's own edge; outputs lag one cycle
  // and read zero while reset is applied
  always @(posedge clk) begin
    cyc++;
    if (rst) begin
      sh <= rsv;
      sd <= '{default: 8'h00};
      ev <= 1'b0;
      eh <= 1'b0;
      erd <= 8'h00;
    end else begin
      sd <= sh;
      ev <= reg_rd;
      eh <= (reg_rd | reg_wr) & mp(reg_addr);
      if (reg_rd) erd <= mp(reg_addr) ?
        sh[reg_addr - RFXCB_OFS_NUM1_LOW] : 8'h00;
      if (reg_wr && mp(reg_addr))
        sh[reg_addr - RFXCB_OFS_NUM1_LOW] <= reg_wdata;
    end
    if (cyc > 3000) begin
      miscompares++;
      close_out();
    end
  end
  // Settled outputs sampled mid-cycle
  always @(negedge clk) if (!rst) begin
    chk(reg_rvalid === ev && reg_hit === eh, "strobes");
    chk(reg_rdata === erd, "read data");
    chk({k0, k1, k2} === {8'h00, sd[0], sd[1], sd[2], sd[3], sd[4]},
      "lo");
    chk({k3, k4, k5} === {sd[5], sd[6], sd[7], sd[8], sd[9], 8'h00},
      "hi");
  end

  initial begin
    rsv = '{RFXCB_RST_NUM1_LOW, RFXCB_RST_NUM2_HIGH, RFXCB_RST_NUM2_LOW,
      RFXCB_RST_NUM3_HIGH, RFXCB_RST_NUM3_LOW, RFXCB_RST_NUM4_HIGH,
      RFXCB_RST_NUM4_LOW, RFXCB_RST_NUM5_HIGH, RFXCB_RST_NUM5_LOW,
      RFXCB_RST_DEN1_HIGH};
    do_rst();
    // Walk the bank with an unmapped neighbour at each end
    for (i = 0; i < 12; i++) begin
      seed = xs(seed);
      op(1'b1, 1'b0, 7'h1d + 7'(i), seed[7:0]);
      op(1'b0, 1'b1, 7'h1d + 7'(i), 8'h00);
    end
    op(1'b1, 1'b1, 7'h7f, 8'hff);
    op(1'b1, 1'b1, RFXCB_OFS_NUM5_LOW, 8'ha5);
    op(1'b0, 1'b1, RFXCB_OFS_NUM5_LOW, 8'h00);
    $display("walk done");
    // pairs written while the datapath is unused
    pair(8'h80, 8'h00, 16'sh8000);
    pair(8'h7f, 8'hff, 16'sh7fff);
    $display("range done");
    // Random mix, addresses spill past both ends
    for (i = 0; i < 400; i++) begin
      seed = xs(seed);
      op(seed[12], seed[13], 7'h1c + 7'(seed[11:8]), seed[7:0]);
    end
    $display("random done");
    op(1'b0, 1'b0, 7'h00, 8'h00);
    do_rst();
    for (i = 0; i < 10; i++) op(1'b0, 1'b1, 7'h1e + 7'(i), 8'h00);
    op(1'b0, 1'b0, 7'h00, 8'h00);
    $display("reset done");
    close_out();
  end
endmodule
`default_nettype wire
